// ==== hw/mss_pkg.sv ====
`default_nettype none
package mss_pkg;
  // excitation modes, coded as {select_1, select_0}
  typedef enum logic [1:0] {
    MSS_TWO_PHASE = 2'b00,
    MSS_ONE_TWO = 2'b01,
    MSS_W_ONE_TWO = 2'b10,
    MSS_TWO_W_ONE_TWO = 2'b11
  } mss_mode_e;

  localparam int MSS_POS_W = 5;
  localparam int MSS_AMP_W = 8;
  localparam logic [MSS_POS_W-1:0] MSS_POS_INIT = 5'h00;
  localparam logic signed [MSS_AMP_W-1:0] MSS_FULL_POS = 8'sh64;
  localparam logic signed [MSS_AMP_W-1:0] MSS_FULL_NEG = -8'sh64;
  localparam logic signed [MSS_AMP_W-1:0] MSS_ZERO = 8'sh00;
  // two-phase table starts half a step (4 entries) back so A=+100, B=-100
  localparam logic [MSS_POS_W-1:0] MSS_TWO_PHASE_OFS = 5'h1c;
  localparam int MSS_CLK_HZ = 10000000;
  localparam int MSS_STEP_MAX_HZ = 5000;
endpackage
`default_nettype wire

// ==== hw/mss_sequencer.sv ====
// Overview of operation
// - enable high floats all winding outputs
// - position advances while outputs disabled
// - re-enable drives the reached position
// - reset low: outputs off, hold, monitor low
// - restart from initial position after reset
// - initial currents per excitation mode
// - decode two selects into four modes
// - qualified edges step cw or ccw
// - monitor low only at the initial position
`timescale 1ns/1ps
`default_nettype none
module mss_sequencer
  import mss_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic step_clock_a_in,
  input wire logic step_clock_b_in,
  input wire logic rotation_direction_in,
  input wire logic excitation_select_0_in,
  input wire logic excitation_select_1_in,
  input wire logic output_enable_n_in,
  output logic signed [MSS_AMP_W-1:0] current_a_out,
  output logic signed [MSS_AMP_W-1:0] current_b_out,
  output logic winding_oe_out,
  output logic position_monitor_n_out
);
  // ************************************************************
  // step qualification
  // ************************************************************
  mss_step_if step_if ();

  mss_step_qual mss_step_qual_inst (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .step_clock_a_in(step_clock_a_in),
    .step_clock_b_in(step_clock_b_in),
    .rotation_direction_in(rotation_direction_in),
    .step(step_if.gen)
  );

  // ************************************************************
  // mode decode and position counter
  // ************************************************************
  mss_mode_e mode;
  logic two_phase;
  logic step_fwd;
  logic step_rev;
  logic [MSS_POS_W-1:0] pos_reg;
  logic [MSS_POS_W-1:0] pos_next;
  logic [MSS_POS_W-1:0] incr;
  logic [MSS_POS_W-1:0] idx;

  // modulo-32 position arithmetic; the carry out is dropped on purpose
  function automatic logic [MSS_POS_W-1:0] mss_pos_add(
    input logic [MSS_POS_W-1:0] p,
    input logic [MSS_POS_W-1:0] d
  );
    logic [MSS_POS_W:0] sum;
    begin
      sum = {1'b0, p} + {1'b0, d};
      mss_pos_add = sum[MSS_POS_W-1:0];
    end
  endfunction

  // subtraction as addition of the two's complement, same wrap
  function automatic logic [MSS_POS_W-1:0] mss_pos_sub(
    input logic [MSS_POS_W-1:0] p,
    input logic [MSS_POS_W-1:0] d
  );
    begin
      mss_pos_sub = mss_pos_add(p, ~d + 5'h01);
    end
  endfunction

  // table step size: 8, 4, 2, 1 entries of the 32-entry cycle
  function automatic logic [MSS_POS_W-1:0] mss_step_size(
    input mss_mode_e m
  );
    begin
      unique case (m)
        MSS_TWO_PHASE: mss_step_size = 5'h08;
        MSS_ONE_TWO: mss_step_size = 5'h04;
        MSS_W_ONE_TWO: mss_step_size = 5'h02;
        MSS_TWO_W_ONE_TWO: mss_step_size = 5'h01;
      endcase
    end
  endfunction

  assign mode = mss_mode_e'({excitation_select_1_in, excitation_select_0_in});
  assign two_phase = (mode == MSS_TWO_PHASE);
  assign incr = mss_step_size(mode);

  // both qualifiers can fire on one edge; forward wins
  assign step_fwd = step_if.step_cw;
  assign step_rev = step_if.step_ccw & ~step_if.step_cw;

  // counter ignores the output enable on purpose
  always_comb begin
    pos_next = pos_reg;
    if (step_fwd) begin
      pos_next = mss_pos_add(pos_reg, incr);
    end else if (step_rev) begin
      pos_next = mss_pos_sub(pos_reg, incr);
    end
  end

  // ************************************************************
  // position register
  // ************************************************************

  // a mode change mid-run keeps the position; coarse modes then
  // step from a fine point, a trade against forcing a re-reset
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      pos_reg <= MSS_POS_INIT;
    end else begin
      pos_reg <= pos_next;
    end
  end

  // ************************************************************
  // sine table
  // ************************************************************
  // quarter-wave of 100*sin(k*pi/16), k = 0..8
  function automatic logic signed [MSS_AMP_W-1:0] mss_sine(
    input logic [MSS_POS_W-1:0] p
  );
    logic [3:0] k;
    logic [7:0] m;
    begin
      k = p[3] ? (4'h8 - {1'b0, p[2:0]}) : {1'b0, p[2:0]};
      if (p[2:0] == 3'h0 && p[3]) begin
        k = 4'h8;
      end
      unique case (k)
        4'h0: m = 8'h00;
        4'h1: m = 8'h14;
        4'h2: m = 8'h26;
        4'h3: m = 8'h38;
        4'h4: m = 8'h47;
        4'h5: m = 8'h53;
        4'h6: m = 8'h5c;
        4'h7: m = 8'h62;
        default: m = 8'h64;
      endcase
      if (p[4]) begin
        mss_sine = -$signed(m);
      end else begin
        mss_sine = $signed(m);
      end
    end
  endfunction

  // full drive on both windings, sign from the quadrant
  function automatic logic signed [MSS_AMP_W-1:0] mss_square(
    input logic signed [MSS_AMP_W-1:0] v
  );
    begin
      if (v < 0) begin
        mss_square = MSS_FULL_NEG;
      end else begin
        mss_square = MSS_FULL_POS;
      end
    end
  endfunction

  // two-phase sits on the 45 degree diagonals, offset so start = (+,-)
  assign idx = two_phase ? mss_pos_add(pos_reg, MSS_TWO_PHASE_OFS) : pos_reg;

  logic signed [MSS_AMP_W-1:0] a_val;
  logic signed [MSS_AMP_W-1:0] b_val;

  always_comb begin
    a_val = mss_sine(mss_pos_add(idx, 5'h08));
    b_val = mss_sine(idx);
    if (two_phase) begin
      a_val = mss_square(a_val);
      b_val = mss_square(b_val);
    end
  end

  // ************************************************************
  // winding currents
  // ************************************************************
  // currents track the position while disabled, so re-enable needs no catch-up
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      current_a_out <= MSS_ZERO;
      current_b_out <= MSS_ZERO;
    end else begin
      current_a_out <= a_val;
      current_b_out <= b_val;
    end
  end

  // ************************************************************
  // winding output enable
  // ************************************************************
  // the pin drivers float the windings while this is low
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      winding_oe_out <= 1'b0;
    end else begin
      winding_oe_out <= ~output_enable_n_in;
    end
  end

  // ************************************************************
  // position monitor
  // ************************************************************
  // taken from the next position so it moves on the step edge itself
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      position_monitor_n_out <= 1'b0;
    end else begin
      position_monitor_n_out <= (pos_next != MSS_POS_INIT);
    end
  end
endmodule // mss_sequencer
`default_nettype wire

// ==== hw/mss_step_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface mss_step_if;
  logic step_cw;
  logic step_ccw;
  modport gen (output step_cw, output step_ccw);
  modport use_p (input step_cw, input step_ccw);
endinterface
`default_nettype wire

// ==== hw/mss_step_qual.sv ====
`timescale 1ns/1ps
`default_nettype none
module mss_step_qual
  import mss_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic step_clock_a_in,
  input wire logic step_clock_b_in,
  input wire logic rotation_direction_in,
  mss_step_if.gen step
);
  logic a_reg;
  logic b_reg;
  logic a_rise;
  logic b_rise;

  // tracks the pins through reset too, so a clock that is already
  // high at release is not taken for a fresh edge
  always_ff @(posedge core_clk_in) begin
    a_reg <= step_clock_a_in;
    b_reg <= step_clock_b_in;
  end

  // edge qualified only while the other clock is high
  assign a_rise = step_clock_a_in & ~a_reg & step_clock_b_in;
  assign b_rise = step_clock_b_in & ~b_reg & step_clock_a_in;
  // reset gates both qualifiers, so nothing steps while held
  assign step.step_cw = resetn_in & (rotation_direction_in ? b_rise : a_rise);
  assign step.step_ccw = resetn_in & (rotation_direction_in ? a_rise : b_rise);
endmodule // mss_step_qual
`default_nettype wire

// ==== verification/mss_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module mss_host_model (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic use_b_in,
  input wire logic hold_in,
  output logic step_clock_a_out,
  output logic step_clock_b_out
);
  // idle high; a one-cycle low then rise is one step, far faster than a real host
  always_ff @(posedge clk_in) begin
    step_clock_a_out <= !(go_in && !use_b_in) && !(hold_in && use_b_in);
    step_clock_b_out <= !(go_in && use_b_in) && !(hold_in && !use_b_in);
  end
endmodule // mss_host_model
`default_nettype wire

// ==== verification/mss_sequencer_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module mss_sequencer_monitor
  import mss_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic step_clock_a_in,
  input wire logic step_clock_b_in,
  input wire logic excitation_select_0_in,
  input wire logic excitation_select_1_in,
  input wire logic output_enable_n_in,
  input wire logic signed [MSS_AMP_W-1:0] current_a_out,
  input wire logic signed [MSS_AMP_W-1:0] current_b_out,
  input wire logic winding_oe_out,
  input wire logic position_monitor_n_out
);
  logic a_reg, b_reg, qual;
  wire logic [1:0] sel = {excitation_select_1_in, excitation_select_0_in};
  // follows the pins through reset, so no edge is seen at release
  always_ff @(posedge core_clk_in) begin
    a_reg <= step_clock_a_in;
    b_reg <= step_clock_b_in;
  end
  assign qual = resetn_in & step_clock_a_in & step_clock_b_in & (~a_reg | ~b_reg);
  default clocking @(posedge core_clk_in); endclocking
  a_oe_follow: assert property (resetn_in && $past(resetn_in) |->
    winding_oe_out == !$past(output_enable_n_in)) else $error("oe not following enable");
  a_reset_off: assert property (!resetn_in |=> !winding_oe_out
    && current_a_out == 0 && current_b_out == 0) else $error("outputs on in reset");
  a_reset_mon: assert property (!resetn_in |=> !position_monitor_n_out)
    else $error("monitor high in reset");
  a_no_idle: assert property ($past(resetn_in) && $changed(position_monitor_n_out)
    |-> $past(qual)) else $error("move without qualified edge");
  a_leave_init: assert property (qual && !position_monitor_n_out |=>
    position_monitor_n_out) else $error("step did not leave initial");
  a_cur_follow: assert property ($past(resetn_in) && $changed(position_monitor_n_out)
    |=> $changed(current_a_out) || $changed(current_b_out)) else $error("currents stuck");
  a_init_cur: assert property ($past(resetn_in) && !position_monitor_n_out
    && !$past(position_monitor_n_out) && $stable(sel) && $past(sel) == $past(sel, 2)
    |-> current_a_out == MSS_FULL_POS
    && current_b_out == (sel == 2'h0 ? MSS_FULL_NEG : MSS_ZERO)) else $error("bad initial");
  a_cur_range: assert property (current_a_out <= MSS_FULL_POS
    && current_a_out >= MSS_FULL_NEG) else $error("current a out of range");
  c_step: cover property (qual && !position_monitor_n_out);
  c_off_step: cover property (qual && output_enable_n_in);
  c_reset: cover property ($fell(resetn_in));
endmodule // mss_sequencer_monitor
`default_nettype wire

// ==== verification/mss_sequencer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module mss_sequencer_tb;
  import mss_pkg::*;
  logic core_clk_in = 0, resetn_in = 0, go = 0, use_b = 0, hold = 0;
  logic rotation_direction_in = 0, output_enable_n_in = 0;
  logic excitation_select_0_in = 0, excitation_select_1_in = 0;
  logic step_clock_a_in, step_clock_b_in, winding_oe_out, position_monitor_n_out;
  logic signed [MSS_AMP_W-1:0] current_a_out, current_b_out;
  int errors = 0, checks = 0;
  always #50 core_clk_in = ~core_clk_in;
  mss_sequencer mss_sequencer_inst (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .step_clock_a_in(step_clock_a_in), .step_clock_b_in(step_clock_b_in),
    .rotation_direction_in(rotation_direction_in),
    .excitation_select_0_in(excitation_select_0_in),
    .excitation_select_1_in(excitation_select_1_in),
    .output_enable_n_in(output_enable_n_in), .current_a_out(current_a_out),
    .current_b_out(current_b_out), .winding_oe_out(winding_oe_out),
    .position_monitor_n_out(position_monitor_n_out));
  mss_host_model mss_host_model_inst (.clk_in(core_clk_in), .go_in(go), .use_b_in(use_b),
    .hold_in(hold), .step_clock_a_out(step_clock_a_in), .step_clock_b_out(step_clock_b_in));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  task automatic step(input logic b);
    use_b = b;
    go = 1;
    cyc(1);
    go = 0;
    cyc(5);
  endtask
  // clocks idle high through the release; that must not count as a step
  task automatic rst;
    resetn_in = 0;
    cyc(6);
    chk("mon", position_monitor_n_out, 0);
    chk("oe", winding_oe_out, 0);
    resetn_in = 1;
    cyc(2);
    chk("mon", position_monitor_n_out, 0);
  endtask
  task automatic final_report;
    if (errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    rst();
    chk("a", current_a_out, MSS_FULL_POS);
    chk("b", current_b_out, MSS_FULL_NEG);
    for (int m = 0; m < 4; m++) begin
      {excitation_select_1_in, excitation_select_0_in} = m[1:0];
      cyc(3);
      if (m > 0) chk("b", current_b_out, MSS_ZERO);
      for (int s = 1; s <= (32 >> (3 - m)); s++) begin
        step(0);
        chk("mon", position_monitor_n_out, s != (32 >> (3 - m)));
      end
    end
    rotation_direction_in = 1;
    step(0);
    chk("b", current_b_out, 8'hec);
    step(1);
    chk("mon", position_monitor_n_out, 0);
    step(0);
    rotation_direction_in = 0;
    step(0);
    chk("mon", position_monitor_n_out, 0);
    hold = 1;
    step(0);
    hold = 0;
    cyc(5);
    chk("mon", position_monitor_n_out, 1);
    step(0);
    output_enable_n_in = 1;
    cyc(2);
    chk("oe", winding_oe_out, 0);
    step(0);
    chk("mon", position_monitor_n_out, 1);
    output_enable_n_in = 0;
    cyc(2);
    chk("a", current_a_out, 8'h62);
    chk("b", current_b_out, 8'h14);
    chk("oe", winding_oe_out, 1);
    resetn_in = 0;
    step(0);
    chk("mon", position_monitor_n_out, 0);
    chk("a", current_a_out, MSS_ZERO);
    rst();
    chk("a", current_a_out, MSS_FULL_POS);
    chk("b", current_b_out, MSS_ZERO);
    final_report();
  end
endmodule // mss_sequencer_tb
bind mss_sequencer mss_sequencer_monitor mss_sequencer_monitor_inst (
  .core_clk_in(core_clk_in), .resetn_in(resetn_in),
  .step_clock_a_in(step_clock_a_in), .step_clock_b_in(step_clock_b_in),
  .excitation_select_0_in(excitation_select_0_in),
  .excitation_select_1_in(excitation_select_1_in),
  .output_enable_n_in(output_enable_n_in), .current_a_out(current_a_out),
  .current_b_out(current_b_out), .winding_oe_out(winding_oe_out),
  .position_monitor_n_out(position_monitor_n_out));
`default_nettype wire
